// file: src/fla_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef FLA_REGS_SVH
`define FLA_REGS_SVH

// ==========================================================
// Register offsets
`define FLA_OFF_ACCESS     8'hf7
`define FLA_OFF_CMD        8'he0
`define FLA_OFF_ADDR_LO    8'he1
`define FLA_OFF_ADDR_HI    8'he2
`define FLA_OFF_DATA       8'he3
`define FLA_OFF_RESULT     8'he4
`define FLA_OFF_STATUS     8'he5
`define FLA_OFF_IRQ_STAT   8'he6
`define FLA_OFF_IRQ_MASK   8'he7
`define FLA_OFF_LOCK       8'he8

// ==========================================================
// Fields and reset values
`define FLA_ACCESS_BIT     0
`define FLA_LOCK_RESET     6'h3f
`define FLA_BLANK_BYTE     8'hff
`define FLA_SECTOR_BITS    9
`define FLA_CODE_BYTES     17'h0f800
`define FLA_DATA_BYTES     17'h00800
`define FLA_IAP_ENTRY      16'hfff0

// ==========================================================
// Return codes
`define FLA_RC_OK          8'h80
`define FLA_RC_PROG_FAIL   8'hfc
`define FLA_RC_ADDR_FAIL   8'hfd
`define FLA_RC_LOCK_FAIL   8'hfe

// ==========================================================
// Serial command codes
`define FLA_ISP_BLANK      8'h01
`define FLA_ISP_ERASE      8'h02
`define FLA_ISP_READ_CODE  8'h03
`define FLA_ISP_READ_DATA  8'h04
`define FLA_ISP_WRITE_CODE 8'h05
`define FLA_ISP_WRITE_DATA 8'h06
`define FLA_ISP_VERIFY     8'h07

// ==========================================================
// Timing: program step time in microseconds, clock in MHz
`define FLA_PROG_US        20
`define FLA_CLK_MHZ        20
`define FLA_PROG_CYC       (`FLA_PROG_US * `FLA_CLK_MHZ)

`endif

// file: src/fla_pkg.sv
// Types shared by the flash access block
package fla_pkg;

	// ==========================================================
	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} fla_bus_type;

	// Protection permissions
	typedef struct packed {
		logic code_prog;
		logic code_read;
		logic data_prog;
		logic data_read;
		logic debug;
		logic in_app_programming;
	} fla_perm_type;

	// Operation kinds
	typedef enum logic [2:0] {
		FLA_OP_NONE,
		FLA_OP_READ,
		FLA_OP_WRITE,
		FLA_OP_ERASE_SECTOR,
		FLA_OP_BLANK,
		FLA_OP_ERASE_CHIP,
		FLA_OP_VERIFY
	} fla_op_type;

endpackage

// file: src/fla_access.sv
// Flash and user-data access with lock protection, serial and in-app paths
//
// Functional notes
// - Six lock bits, 1 unprogrammed, none protects
// - Level is one plus highest programmed bit
// - Each level blocks one more function
// - Serial programming uses clock, data, strobe pins
// - Blank check confirms both arrays unprogrammed; serial answer reads 80 even when not blank, result register shows the fail
// - Chip erase clears both arrays
// - Read returns data, write programs data
// - Verify reports success or mismatch count
// - Arrays programmable while code runs
// - Byte program, 512-byte sector erase
// - Routine entered at fixed top address
// - Return code in accumulator shows outcome; here it is read from the result register instead
// - Status word may change across routine
// - CPU stalled, interrupts deferred meanwhile
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fla_regs.svh"

module fla_access
	import fla_pkg::*;
#(
	parameter int CODE_AW   = 16,
	parameter int DATA_AW   = 11,
	parameter int PROG_CYC  = `FLA_PROG_CYC
)(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// CPU side
	input  wire logic [15:0] cpu_pc,
	output logic            cpu_stall,
	output logic            irq_defer,
	output logic            psw_clobber,
	output logic            irq,
	// Serial programming pins
	input  wire logic       prog_serial_clock,
	input  wire logic       prog_serial_io_in,
	output logic            prog_serial_io_out,
	output logic            prog_serial_io_oe,
	input  wire logic       program_store_strobe_n,
	// Protection view
	output logic            debug_serial_port_en
);

	// ==========================================================
	// Storage arrays; both power up unprogrammed in this model
	logic [7:0] code_mem [0:(1<<CODE_AW)-1] = '{default: `FLA_BLANK_BYTE};
	logic [7:0] data_mem [0:(1<<DATA_AW)-1] = '{default: `FLA_BLANK_BYTE};

	// ==========================================================
	// Registers
	fla_bus_type  bus;
	logic [5:0]   lock_reg;
	logic [7:0]   access_reg, cmd_reg, addr_lo_reg, addr_hi_reg;
	logic [7:0]   data_reg, result_reg, irq_stat_reg, irq_mask_reg;
	logic [15:0]  mism_reg;
	logic [2:0]   level;
	fla_perm_type perm;

	assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// Level from the highest programmed (zero) lock bit
	function automatic logic [2:0] lock_level(input logic [5:0] lb);
		logic [2:0] lv;
		lv = 3'h0;
		for (int i = 0; i < 6; i++) begin
			if (!lb[i]) begin
				lv = 3'(i + 1);
			end
		end
		return lv;
	endfunction

	// Cumulative disables
	assign level = lock_level(lock_reg);
	assign perm.code_prog = (level < 3'h1);
	assign perm.code_read = (level < 3'h2);
	assign perm.data_prog = (level < 3'h3);
	assign perm.data_read = (level < 3'h4);
	assign perm.debug     = (level < 3'h5);
	assign perm.in_app_programming       = (level < 3'h6);

	// ==========================================================
	// Serial link sampled by three flops, edge when last two agree
	logic [2:0] sck_s, sda_s, ps_s;
	logic       sck_q, sck_rise;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sck_s <= 3'h0;
			sda_s <= 3'h0;
			ps_s  <= 3'h7;
		end else begin
			sck_s <= {sck_s[1:0], prog_serial_clock};
			sda_s <= {sda_s[1:0], prog_serial_io_in};
			ps_s  <= {ps_s[1:0], program_store_strobe_n};
		end
	end
	// Filtered clock level moves only when second and third agree
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sck_q <= 1'b0;
		end else if (sck_s[1] == sck_s[2]) begin
			sck_q <= sck_s[2];
		end
	end
	assign sck_rise = (sck_s[1] == sck_s[2]) && sck_s[2] && !sck_q;

	// Serial frame: strobe low selects; bytes shift msb first
	// Frame = cmd, addr hi, addr lo, data; answer byte shifts out after
	logic        isp_sel;
	logic [7:0]  sh_reg;
	logic [2:0]  bit_cnt;
	logic [1:0]  byte_cnt;
	logic [7:0]  icmd_reg, iah_reg, ial_reg, tx_reg;
	logic        isp_go;
	logic        byte_done;
	assign isp_sel   = !ps_s[2];
	assign byte_done = sck_rise && (bit_cnt == 3'h7);
	always_ff @(posedge sys_clk) begin
		if (rst || !isp_sel) begin
			bit_cnt  <= 3'h0;
			byte_cnt <= 2'h0;
			sh_reg   <= 8'h00;
			isp_go   <= 1'b0;
		end else begin
			isp_go <= 1'b0;
			if (sck_rise) begin
				sh_reg  <= {sh_reg[6:0], sda_s[2]};
				bit_cnt <= bit_cnt + 3'h1;
			end
			if (byte_done) begin
				byte_cnt <= byte_cnt + 2'h1;
				isp_go   <= (byte_cnt == 2'h3);
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			icmd_reg <= 8'h00;
			iah_reg  <= 8'h00;
			ial_reg  <= 8'h00;
		end else if (byte_done) begin
			case (byte_cnt)
				2'h0: icmd_reg <= {sh_reg[6:0], sda_s[2]};
				2'h1: iah_reg  <= {sh_reg[6:0], sda_s[2]};
				2'h2: ial_reg  <= {sh_reg[6:0], sda_s[2]};
				default: ;
			endcase
		end
	end
	logic [7:0] isp_wdata;
	assign isp_wdata = sh_reg;

	// ==========================================================
	// Operation engine shared by both paths
	typedef enum {ST_IDLE, ST_BUSY, ST_SWEEP, ST_DONE} fla_st_type;
	fla_st_type  st_reg;
	fla_op_type  op_reg;
	logic        tgt_data_reg, from_isp_reg, ok_reg;
	logic [16:0] ptr_reg;
	logic [15:0] timer_reg;
	logic [7:0]  wbyte_reg, iap_byte_reg;

	// Command decoding for the serial path only
	function automatic fla_op_type isp_op(input logic [7:0] c);
		case (c)
			`FLA_ISP_BLANK:      return FLA_OP_BLANK;
			`FLA_ISP_ERASE:      return FLA_OP_ERASE_CHIP;
			`FLA_ISP_READ_CODE,
			`FLA_ISP_READ_DATA:  return FLA_OP_READ;
			`FLA_ISP_WRITE_CODE,
			`FLA_ISP_WRITE_DATA: return FLA_OP_WRITE;
			`FLA_ISP_VERIFY:     return FLA_OP_VERIFY;
			default:             return FLA_OP_NONE;
		endcase
	endfunction
	function automatic logic isp_tgt_data(input logic [7:0] c);
		return (c == `FLA_ISP_READ_DATA) || (c == `FLA_ISP_WRITE_DATA);
	endfunction

	// In-app request: cmd register write while PC is at the entry
	logic        iap_req, isp_req, start;
	fla_op_type  new_op;
	logic        new_tgt, allowed, addr_ok;
	logic [15:0] new_addr;
	logic        in_range;
	assign iap_req  = bus.wr && (bus.addr == `FLA_OFF_CMD) &&
		(cpu_pc == `FLA_IAP_ENTRY) && (st_reg == ST_IDLE);
	assign isp_req  = isp_go && (st_reg == ST_IDLE);
	assign start    = iap_req || isp_req;
	assign new_op   = isp_req ? isp_op(icmd_reg) : fla_op_type'(bus.wdata[2:0]);
	assign new_tgt  = isp_req ? isp_tgt_data(icmd_reg) : bus.wdata[7];
	assign new_addr = isp_req ? {iah_reg, ial_reg} : {addr_hi_reg, addr_lo_reg};
	assign in_range = new_tgt ? ({1'b0, new_addr} < `FLA_DATA_BYTES)
		: ({1'b0, new_addr} < `FLA_CODE_BYTES);
	assign addr_ok  = in_range || (new_op == FLA_OP_BLANK) ||
		(new_op == FLA_OP_ERASE_CHIP) || (new_op == FLA_OP_VERIFY);

	// Lock and flag gating, erase chip stays open on the serial path to recover
	always_comb begin
		case (new_op)
			FLA_OP_READ, FLA_OP_VERIFY:
				allowed = new_tgt ? perm.data_read : perm.code_read;
			FLA_OP_WRITE, FLA_OP_ERASE_SECTOR:
				allowed = new_tgt ? perm.data_prog : perm.code_prog;
			FLA_OP_BLANK, FLA_OP_ERASE_CHIP:
				allowed = 1'b1;
			default:
				allowed = 1'b0;
		endcase
		if (iap_req && (!perm.in_app_programming || !access_reg[`FLA_ACCESS_BIT])) begin
			allowed = 1'b0;
		end
	end

	// Engine sequencing
	logic [CODE_AW-1:0] ca;
	logic [DATA_AW-1:0] da;
	logic               sweep_last, tick;
	assign ca         = ptr_reg[CODE_AW-1:0];
	assign da         = ptr_reg[DATA_AW-1:0];
	assign sweep_last = (ptr_reg == `FLA_CODE_BYTES - 17'h1);
	assign tick       = (timer_reg == 16'h0);
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_reg       <= ST_IDLE;
			op_reg       <= FLA_OP_NONE;
			tgt_data_reg <= 1'b0;
			from_isp_reg <= 1'b0;
			ok_reg       <= 1'b1;
			ptr_reg      <= 17'h0;
			timer_reg    <= 16'h0;
			result_reg   <= `FLA_RC_OK;
			mism_reg     <= 16'h0;
			wbyte_reg    <= 8'h00;
		end else begin
			case (st_reg)
				ST_IDLE: if (start) begin
					op_reg       <= new_op;
					tgt_data_reg <= new_tgt;
					from_isp_reg <= isp_req;
					wbyte_reg    <= isp_req ? isp_wdata : data_reg;
					timer_reg    <= 16'(PROG_CYC);
					ok_reg       <= 1'b1;
					mism_reg     <= 16'h0;
					ptr_reg      <= {1'b0, new_addr};
					if (!allowed) begin
						result_reg <= `FLA_RC_LOCK_FAIL;
						st_reg     <= ST_DONE;
					end else if (!addr_ok) begin
						result_reg <= `FLA_RC_ADDR_FAIL;
						st_reg     <= ST_DONE;
					end else if (new_op == FLA_OP_BLANK ||
						new_op == FLA_OP_ERASE_CHIP ||
						new_op == FLA_OP_VERIFY) begin
						ptr_reg <= 17'h0;
						st_reg  <= ST_SWEEP;
					end else begin
						st_reg <= ST_BUSY;
					end
				end
				// Single byte or sector; held for program time
				ST_BUSY: begin
					timer_reg <= timer_reg - 16'h1;
					if (tick) begin
						st_reg     <= ST_DONE;
						result_reg <= `FLA_RC_OK;
						// Old byte is read here; programming only clears bits
						if (op_reg == FLA_OP_WRITE && ((tgt_data_reg ?
							data_mem[da] : code_mem[ca]) & wbyte_reg)
							!= wbyte_reg) begin
							result_reg <= `FLA_RC_PROG_FAIL;
						end
					end
				end
				// Whole-array walk for blank, erase and verify
				ST_SWEEP: begin
					ptr_reg <= ptr_reg + 17'h1;
					if (op_reg == FLA_OP_BLANK && (code_mem[ca] != `FLA_BLANK_BYTE
						|| (ptr_reg < `FLA_DATA_BYTES &&
						data_mem[da] != `FLA_BLANK_BYTE))) begin
						ok_reg <= 1'b0;
					end
					if (op_reg == FLA_OP_VERIFY && ptr_reg < `FLA_DATA_BYTES &&
						code_mem[ca] != data_mem[da]) begin
						mism_reg <= mism_reg + 16'h1;
					end
					if (sweep_last) begin
						st_reg     <= ST_DONE;
						result_reg <= `FLA_RC_OK;
					end
				end
				default: begin
					st_reg <= ST_IDLE;
					if (op_reg == FLA_OP_VERIFY && mism_reg != 16'h0) begin
						result_reg <= `FLA_RC_PROG_FAIL;
					end
					if (op_reg == FLA_OP_BLANK && !ok_reg) begin
						result_reg <= `FLA_RC_PROG_FAIL;
					end
				end
			endcase
		end
	end

	// Array writes; stored data only changes on permitted ops
	always_ff @(posedge sys_clk) begin
		if (st_reg == ST_BUSY && tick && op_reg == FLA_OP_WRITE) begin
			if (tgt_data_reg) begin
				data_mem[da] <= data_mem[da] & wbyte_reg;
			end else begin
				code_mem[ca] <= code_mem[ca] & wbyte_reg;
			end
		end
		if (st_reg == ST_BUSY && op_reg == FLA_OP_ERASE_SECTOR) begin
			// Sector walk: erase the aligned 512-byte sector holding the address
			for (int i = 0; i < (1 << `FLA_SECTOR_BITS); i++) begin
				if (tick && tgt_data_reg) begin
					data_mem[{da[DATA_AW-1:`FLA_SECTOR_BITS],
						9'(i)}] <= `FLA_BLANK_BYTE;
				end else if (tick) begin
					code_mem[{ca[CODE_AW-1:`FLA_SECTOR_BITS],
						9'(i)}] <= `FLA_BLANK_BYTE;
				end
			end
		end
		if (st_reg == ST_SWEEP && op_reg == FLA_OP_ERASE_CHIP) begin
			code_mem[ca] <= `FLA_BLANK_BYTE;
			if (ptr_reg < `FLA_DATA_BYTES) begin
				data_mem[da] <= `FLA_BLANK_BYTE;
			end
		end
	end

	// Read byte capture for both paths
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			iap_byte_reg <= 8'h00;
		end else if (st_reg == ST_BUSY && tick && op_reg == FLA_OP_READ) begin
			iap_byte_reg <= tgt_data_reg ? data_mem[da] : code_mem[ca];
		end
	end

	// Answer byte shifted back while the strobe stays low
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tx_reg             <= 8'h00;
			prog_serial_io_out <= 1'b0;
			prog_serial_io_oe  <= 1'b0;
		end else begin
			if (st_reg == ST_DONE && from_isp_reg) begin
				tx_reg <= (op_reg == FLA_OP_READ) ? iap_byte_reg
					: (op_reg == FLA_OP_VERIFY ? mism_reg[7:0] : result_reg);
				prog_serial_io_oe <= isp_sel;
			end else if (sck_rise && prog_serial_io_oe) begin
				tx_reg <= {tx_reg[6:0], 1'b0};
			end
			if (!isp_sel) begin
				prog_serial_io_oe <= 1'b0;
			end
			prog_serial_io_out <= tx_reg[7];
		end
	end

	// ==========================================================
	// Software registers and interrupt
	logic done_evt, lock_evt;
	assign done_evt = (st_reg == ST_DONE);
	assign lock_evt = done_evt && (result_reg == `FLA_RC_LOCK_FAIL);
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			access_reg   <= 8'h00;
			cmd_reg      <= 8'h00;
			addr_lo_reg  <= 8'h00;
			addr_hi_reg  <= 8'h00;
			data_reg     <= 8'h00;
			irq_mask_reg <= 8'h00;
			irq_stat_reg <= 8'h00;
			lock_reg     <= `FLA_LOCK_RESET;
		end else begin
			if (bus.wr) begin
				case (bus.addr)
					`FLA_OFF_ACCESS:   access_reg   <= bus.wdata;
					`FLA_OFF_CMD:      cmd_reg      <= bus.wdata;
					`FLA_OFF_ADDR_LO:  addr_lo_reg  <= bus.wdata;
					`FLA_OFF_ADDR_HI:  addr_hi_reg  <= bus.wdata;
					`FLA_OFF_DATA:     data_reg     <= bus.wdata;
					`FLA_OFF_IRQ_MASK: irq_mask_reg <= bus.wdata;
					// Writes only take lock bits from 1 to 0; reset sets all six back to 1
					`FLA_OFF_LOCK:     lock_reg <= lock_reg & bus.wdata[5:0];
					default: ;
				endcase
			end
			// Set wins over write-one-to-clear
			irq_stat_reg <= (irq_stat_reg &
				~((bus.wr && bus.addr == `FLA_OFF_IRQ_STAT) ? bus.wdata : 8'h00))
				| {6'h00, lock_evt, done_evt};
		end
	end

	// Read mux, one cycle later; unmapped reads zero
	logic [7:0] rd_mux;
	always_comb begin
		case (bus.addr)
			`FLA_OFF_ACCESS:   rd_mux = access_reg;
			`FLA_OFF_CMD:      rd_mux = cmd_reg;
			`FLA_OFF_ADDR_LO:  rd_mux = addr_lo_reg;
			`FLA_OFF_ADDR_HI:  rd_mux = addr_hi_reg;
			`FLA_OFF_DATA:     rd_mux = iap_byte_reg;
			`FLA_OFF_RESULT:   rd_mux = result_reg;
			`FLA_OFF_STATUS:   rd_mux = {2'h0, (st_reg != ST_IDLE), 2'h0, level};
			`FLA_OFF_IRQ_STAT: rd_mux = irq_stat_reg;
			`FLA_OFF_IRQ_MASK: rd_mux = irq_mask_reg;
			`FLA_OFF_LOCK:     rd_mux = {2'h0, lock_reg};
			default:           rd_mux = 8'h00;
		endcase
	end

	// Outputs all from flops
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata            <= 8'h00;
			cpu_stall            <= 1'b0;
			irq_defer            <= 1'b0;
			psw_clobber          <= 1'b0;
			irq                  <= 1'b0;
			debug_serial_port_en <= 1'b1;
		end else begin
			reg_rdata <= bus.rd ? rd_mux : 8'h00;
			// CPU held and interrupts deferred for in-app ops
			cpu_stall <= start ? iap_req : (cpu_stall && st_reg != ST_DONE);
			irq_defer <= start ? iap_req : (cpu_stall && st_reg != ST_DONE);
			psw_clobber <= iap_req; // flags left undefined
			irq <= |(irq_stat_reg & irq_mask_reg);
			debug_serial_port_en <= perm.debug;
		end
	end

endmodule
`default_nettype wire

// file: bench/fla_access_monitor.sv
// Port-level assertion checker for the flash access block, with its bind
`timescale 1ns/1ps
`default_nettype none

module fla_access_monitor
	import fla_pkg::*;
#(
	parameter int CODE_AW  = 16,
	parameter int DATA_AW  = 11,
	parameter int PROG_CYC = 400
)(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	// CPU side
	input wire logic [15:0] cpu_pc,
	input wire logic        cpu_stall,
	input wire logic        irq_defer,
	input wire logic        psw_clobber,
	// Serial pins and protection view
	input wire logic        program_store_strobe_n,
	input wire logic        prog_serial_io_oe,
	input wire logic        debug_serial_port_en
);
	// ==========================================================
	// Stall length counter: a whole-array sweep is the longest op
	logic [16:0] stall_cnt_reg;
	logic [16:0] stall_cnt_next;
	assign stall_cnt_next = cpu_stall ? stall_cnt_reg + 17'h00001 : 17'h00000;
	always_ff @(posedge sys_clk) begin
		stall_cnt_reg <= rst ? 17'h00000 : stall_cnt_next;
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// ==========================================================
	// Port relations
	AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside the answer cycle");
	AST_STALL_DEFER: assert property (cpu_stall == irq_defer)
		else $error("interrupt deferral differs from CPU stall");
	AST_STALL_START: assert property ($rose(cpu_stall) |-> $past(reg_wr && reg_addr == 8'he0 && cpu_pc == 16'hfff0))
		else $error("stall began without a command from the entry address");
	AST_PC_GATE: assert property (reg_wr && reg_addr == 8'he0 && cpu_pc != 16'hfff0 && !cpu_stall |=> !cpu_stall)
		else $error("command taken away from the entry address");
	AST_PSW_ONCE: assert property (psw_clobber |=> !psw_clobber)
		else $error("status word warning longer than one cycle");
	AST_PSW_START: assert property ($rose(cpu_stall) |-> ##[0:2] psw_clobber)
		else $error("no status word warning at routine start");
	AST_STALL_BOUND: assert property (stall_cnt_reg < 17'h11170)
		else $error("CPU stall ran too long");
	AST_DEBUG_HOLD: assert property (!$past(reg_wr && reg_addr == 8'he8) && !$past(reg_wr && reg_addr == 8'he8, 2) |-> $stable(debug_serial_port_en))
		else $error("debug enable moved without a lock write");
	AST_OE_IDLE: assert property (program_store_strobe_n [*8] |-> !prog_serial_io_oe)
		else $error("data pin driven outside a frame");
endmodule

bind fla_access fla_access_monitor #(.CODE_AW(CODE_AW), .DATA_AW(DATA_AW),
	.PROG_CYC(PROG_CYC)) i_fla_access_monitor (.sys_clk(sys_clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .cpu_pc(cpu_pc), .cpu_stall(cpu_stall),
	.irq_defer(irq_defer), .psw_clobber(psw_clobber),
	.program_store_strobe_n(program_store_strobe_n),
	.prog_serial_io_oe(prog_serial_io_oe),
	.debug_serial_port_en(debug_serial_port_en));

`default_nettype wire

// file: bench/fla_isp_model.sv
// Serial programmer model driving the in-system programming pins
`timescale 1ns/1ps
`default_nettype none

module fla_isp_model (
	// Pins towards the device
	output var logic  prog_serial_clock,
	output var logic  program_store_strobe_n,
	output wire logic prog_serial_io_in,
	input wire logic  prog_serial_io_out,
	input wire logic  prog_serial_io_oe
);
	logic drv;

	// Data line level: device while it drives, else the programmer
	assign prog_serial_io_in = prog_serial_io_oe ? prog_serial_io_out : drv;

	// Idle pins: clock stands low, strobe high between frames
	initial begin
		prog_serial_clock = 1'b0;
		program_store_strobe_n = 1'b1;
		drv = 1'b0;
	end

	// One frame: 32 request bits msb first, then an 8-bit answer
	task automatic frame(input logic [31:0] req, output logic [7:0] ans);
		int i;
		program_store_strobe_n = 1'b0;
		#400;
		for (i = 31; i >= 0; i--) begin
			drv = req[i];
			#200 prog_serial_clock = 1'b1;
			#200 prog_serial_clock = 1'b0;
		end
		// Released line shows the inverse so a stale bit never passes
		drv = ~drv;
		i = 0;
		while (prog_serial_io_oe !== 1'b1 && i < 70000) begin
			#50;
			i++;
		end
		// Device shows the msb first and shifts on each rise, so sample
		// every bit before the rise that moves it on
		#200;
		for (i = 7; i >= 0; i--) begin
			ans[i] = prog_serial_io_in;
			prog_serial_clock = 1'b1;
			#200 prog_serial_clock = 1'b0;
			#200;
		end
		#200 program_store_strobe_n = 1'b1;
		#400;
	endtask
endmodule

`default_nettype wire

// file: bench/fla_access_bench.sv
// Self-checking testbench for the flash access block
`timescale 1ns/1ps
`default_nettype none

module fla_access_bench;
	logic        sys_clk;
	logic        rst;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] cpu_pc;
	wire  [7:0]  reg_rdata;
	wire         cpu_stall, irq_defer, psw_clobber, irq, dbg_en;
	wire         sck, sio_in, sio_out, sio_oe, strobe_n;
	int          bad_count = 0;
	int          compares = 0;
	int          k;
	int          lv [4];
	logic [7:0]  lock_exp;

	fla_access #(.PROG_CYC(4)) i_fla_access (.sys_clk(sys_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_pc(cpu_pc),
		.cpu_stall(cpu_stall), .irq_defer(irq_defer),
		.psw_clobber(psw_clobber), .irq(irq), .prog_serial_clock(sck),
		.prog_serial_io_in(sio_in), .prog_serial_io_out(sio_out),
		.prog_serial_io_oe(sio_oe), .program_store_strobe_n(strobe_n),
		.debug_serial_port_en(dbg_en));

	fla_isp_model i_fla_isp_model (.prog_serial_clock(sck),
		.program_store_strobe_n(strobe_n), .prog_serial_io_in(sio_in),
		.prog_serial_io_out(sio_out), .prog_serial_io_oe(sio_oe));

	// ==========================================================
	// Clock and watchdog sized well past the erase sweep
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		#4500000;
		bad_count++;
		close_out();
	end

	// ==========================================================
	// Compare, register access and operation tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// Parameters first, command from the entry address, then result
	task automatic in_app_programming(input logic [7:0] op, input logic [15:0] a,
		input logic [7:0] d, input logic [7:0] exp);
		int n;
		n = 0;
		wr(8'he1, a[7:0]);
		wr(8'he2, a[15:8]);
		wr(8'he3, d);
		cpu_pc <= 16'hfff0;
		wr(8'he0, op);
		cpu_pc <= 16'h0000;
		@(posedge sys_clk);
		#1;
		while (cpu_stall === 1'b1 && n < 1000) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n >= 1000) begin
			bad_count++;
			$display("unexpected at %0t: stall did not end", $time);
		end
		rd_chk(8'he4, exp);
	endtask
	task automatic ser(input logic [31:0] req, input logic [7:0] exp);
		logic [7:0] ans;
		i_fla_isp_model.frame(req, ans);
		chk(ans, exp);
	endtask
	task close_out;
		if (bad_count == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		cpu_pc = 16'h0000;
		lv = '{1, 3, 4, 6};
		lock_exp = 8'h3f;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		rd_chk(8'he8, 8'h3f);
		chk({7'h00, dbg_en}, 8'h01);
		rd_chk(8'h10, 8'h00);
		wr(8'hf7, 8'h01);
		wr(8'he7, 8'h01);
		rd_chk(8'hf7, 8'h01);
		in_app_programming(8'h02, 16'h0123, 8'h5a, 8'h80);
		chk({7'h00, irq}, 8'h01);
		wr(8'he6, 8'h03);
		@(posedge sys_clk);
		#1 chk({7'h00, irq}, 8'h00);
		in_app_programming(8'h01, 16'h0123, 8'h00, 8'h80);
		rd_chk(8'he3, 8'h5a);
		in_app_programming(8'h03, 16'h0100, 8'h00, 8'h80);
		in_app_programming(8'h01, 16'h0123, 8'h00, 8'h80);
		rd_chk(8'he3, 8'hff);
		in_app_programming(8'h82, 16'h07ff, 8'ha5, 8'h80);
		in_app_programming(8'h82, 16'h0800, 8'h00, 8'hfd);
		in_app_programming(8'h02, 16'hf800, 8'h00, 8'hfd);
		wr(8'he0, 8'h02);
		rd_chk(8'he4, 8'hfd);
		wr(8'hf7, 8'h00);
		in_app_programming(8'h81, 16'h07ff, 8'h00, 8'hfe);
		wr(8'hf7, 8'h01);
		ser({8'h04, 16'h07ff, 8'h00}, 8'ha5);
		ser({8'h05, 16'h0200, 8'h3c}, 8'h80);
		in_app_programming(8'h01, 16'h0200, 8'h00, 8'h80);
		rd_chk(8'he3, 8'h3c);
		ser({8'h02, 24'h000000}, 8'h80);
		in_app_programming(8'h81, 16'h07ff, 8'h00, 8'h80);
		rd_chk(8'he3, 8'hff);
		wr(8'he7, 8'h00);
		// Levels skip lock bits so lower bits must not matter
		for (k = 0; k < 4; k++) begin
			lock_exp = lock_exp & ~(8'h01 << (lv[k] - 1));
			wr(8'he8, lock_exp);
			rd_chk(8'he8, lock_exp);
			@(posedge sys_clk);
			#1 chk({7'h00, dbg_en}, {7'h00, lv[k] < 5});
			in_app_programming(8'h02, 16'h0300, 8'h11, 8'hfe);
			in_app_programming(8'h01, 16'h0200, 8'h00, lv[k] >= 2 ? 8'hfe : 8'h80);
			in_app_programming(8'h82, 16'h0010, 8'h22, lv[k] >= 3 ? 8'hfe : 8'h80);
			in_app_programming(8'h81, 16'h0010, 8'h00, lv[k] >= 4 ? 8'hfe : 8'h80);
		end
		in_app_programming(8'h86, 16'h0000, 8'h00, 8'hfe);
		chk({7'h00, irq}, 8'h00);
		close_out();
	end
endmodule

`default_nettype wire
